// ### hsdp_map.svh
`ifndef HSDP_MAP_SVH
`define HSDP_MAP_SVH

`define HSDP_WORD_WIDTH      16
`define HSDP_HOLD_RESET      16'h0000
`define HSDP_SHIFT_RESET     16'h0000
`define HSDP_GPC_FLOAT_LINK  3'h5
`define HSDP_SEL_HOLD        2'h0
`define HSDP_SEL_RIGHT       2'h1
`define HSDP_SEL_LEFT        2'h2
`define HSDP_SEL_LOAD        2'h3

`endif

// ### hsdp_pkg.sv
package hsdp_pkg;
    typedef enum logic [1:0] {
        HSDP_HOLD  = 2'h0,
        HSDP_RIGHT = 2'h1,
        HSDP_LEFT  = 2'h2,
        HSDP_LOAD  = 2'h3
    } hsdp_shift_type;
endpackage

// ### hsdp_pulse_edge.sv
`timescale 1ns/100ps
// Synchronises a host timing pulse and flags its trailing edge
module hsdp_pulse_edge (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Pulse in and trailing-edge strobe out
    input  wire logic pulseIn,
    output logic      trailEdge
);
    logic syncA;
    logic syncB;
    logic syncC;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA <= 1'b0;
            syncB <= 1'b0;
            syncC <= 1'b0;
        end else begin
            syncA <= pulseIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    assign trailEdge = syncC & ~syncB;
endmodule // hsdp_pulse_edge

// ### hsdp_datapath.sv
`timescale 1ns/100ps
`include "hsdp_map.svh"
// Behaviour
// RL1: A 16-bit holding word takes its host words from the host data select bus.
// RL2: The holding word loads at the trailing edge of pulse one or three when the microword load enable is set.
// RL3: A 16-bit shifting word shifts left, right or loads in parallel from the holding word.
// RL4: Shift select 0 holds, 1 shifts right, 2 shifts left and 3 loads.
// RL5: The shifting word is clocked on every pulse one and pulse two; only the select code decides change.
// RL6: Every state change happens at the trailing edge of its timing pulse.
// RL7: The host runs three cycle lengths, the first two with one pulse and the third with two.
// RL8: In multiply the word shifts right, the arithmetic unit low bit entering at bit 15.
// RL9: In divide the word shifts left, quotient bits entering at bit 0.
// RL10: Outside multiply a right shift feeds holding word bit 0 into bit 15.
// RL11: A combined arithmetic left shift forces zero into bit 0.
// RL12: With general purpose code 5 the float high shifter bit 15 enters bit 0 on left shifts, else the divide quotient bit or zero.
// RL13: The float link path exists only when the floating extension is fitted, per a build parameter.
// RL14: The bit 0 shift-in is used only on left shifts.
// RL15: Both words are exported as ports.
// RL16: The holding word serves as load source for counter, shifting word and float shifters.
// RL17: Both words clear to zero on reset.
module hsdp_datapath
    import hsdp_pkg::*;
#(
    parameter int  WIDTH          = `HSDP_WORD_WIDTH,
    parameter bit  FLOAT_PRESENT  = 1'b1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Host timing pulses (asynchronous pins)
    input  wire logic             pulseOne,
    input  wire logic             pulseTwo,
    input  wire logic             pulseThree,
    // Host data and microword controls (asynchronous pins)
    input  wire logic [WIDTH-1:0] hostDataSelect,
    input  wire logic             holdingLoadEnable,
    input  wire logic             shiftSelectLow,
    input  wire logic             shiftSelectHigh,
    input  wire logic [2:0]       generalPurposeCode,
    // Operation qualifiers
    input  wire logic             multiplyActive,
    input  wire logic             divideActive,
    input  wire logic             combinedArithShift,
    input  wire logic             quotientBit,
    input  wire logic             arithUnitLsb,
    input  wire logic             floatHighMsb,
    // Observed register outputs
    output logic [WIDTH-1:0]      holdingWord,
    output logic [WIDTH-1:0]      shiftingWord
);
    // Pin synchronisers for data and control
    localparam int CW = WIDTH + 12;
    logic [CW-1:0] pinSyncA;
    logic [CW-1:0] pinSync;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinSyncA <= '0;
            pinSync  <= '0;
        end else begin
            pinSyncA <= {hostDataSelect, holdingLoadEnable, shiftSelectHigh, shiftSelectLow,
                         generalPurposeCode, multiplyActive, divideActive, combinedArithShift,
                         quotientBit, arithUnitLsb, floatHighMsb};
            pinSync  <= pinSyncA;
        end
    end

    logic [WIDTH-1:0] dataS;
    logic             loadEnS;
    logic [1:0]       selS;
    logic [2:0]       gpcS;
    logic             mulS;
    logic             divS;
    logic             ashcS;
    logic             quotS;
    logic             aluS;
    logic             hsrS;

    assign {dataS, loadEnS, selS, gpcS, mulS, divS, ashcS, quotS, aluS, hsrS} = pinSync;

    // Trailing edges of the three timing pulses
    logic trailOne;
    logic trailTwo;
    logic trailThree;

    hsdp_pulse_edge uEdgeOne (
        .clk       (clk),
        .rst_n     (rst_n),
        .pulseIn   (pulseOne),
        .trailEdge (trailOne)
    );
    hsdp_pulse_edge uEdgeTwo (
        .clk       (clk),
        .rst_n     (rst_n),
        .pulseIn   (pulseTwo),
        .trailEdge (trailTwo)
    );
    hsdp_pulse_edge uEdgeThree (
        .clk       (clk),
        .rst_n     (rst_n),
        .pulseIn   (pulseThree),
        .trailEdge (trailThree)
    );

    // Bit 0 shift-in for left shifts
    function automatic logic left_fill(input logic combined_arith_shift, input logic div, input logic [2:0] general_purpose_code,
                                       input logic quot, input logic float_high_shifter);
        logic r;
        r = 1'b0;
        if (combined_arith_shift) begin
            r = 1'b0;                                          // [RL11]
        end else if (FLOAT_PRESENT && general_purpose_code == `HSDP_GPC_FLOAT_LINK) begin
            r = float_high_shifter;                                           // [RL12] [RL13]
        end else if (div) begin
            r = quot;                                          // [RL9]
        end
        return r;
    endfunction

    // Holding word capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            holdingWord <= `HSDP_HOLD_RESET;                   // [RL17]
        end else if ((trailOne || trailThree) && loadEnS) begin
            holdingWord <= dataS;                              // [RL1] [RL2] [RL6] [RL16]
        end
    end

    // Shifting word
    hsdp_shift_type shiftMode;
    assign shiftMode = hsdp_shift_type'(selS);                // [RL4]

    logic rightFill;
    assign rightFill = mulS ? aluS : holdingWord[0];          // [RL8] [RL10]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shiftingWord <= `HSDP_SHIFT_RESET;                 // [RL17]
        end else if (trailOne || trailTwo) begin               // [RL5] [RL6] [RL7]
            unique case (shiftMode)
                HSDP_HOLD: begin
                    shiftingWord <= shiftingWord;
                end
                HSDP_RIGHT: begin
                    shiftingWord <= {rightFill, shiftingWord[WIDTH-1:1]};   // [RL8] [RL14]
                end
                HSDP_LEFT: begin
                    shiftingWord <= {shiftingWord[WIDTH-2:0],
                                     left_fill(ashcS, divS, gpcS, quotS, hsrS)}; // [RL9] [RL14]
                end
                HSDP_LOAD: begin
                    shiftingWord <= holdingWord;               // [RL3] [RL16]
                end
            endcase
        end
    end
    // Both words drive ports directly [RL15]
endmodule // hsdp_datapath

// ### hsdp_host.sv
`timescale 1ns/100ps
// Host timing pulses: one pulse per cycle, two in the third cycle length, action on each fall
module hsdp_host (
    input  wire logic clk,
    output logic      pulseOne = 1'b0,
    output logic      pulseTwo = 1'b0,
    output logic      pulseThree = 1'b0
);
    task automatic pulse(input int k);
        @(negedge clk) {pulseThree, pulseTwo, pulseOne} = 3'(3'h1 << (k - 1));
        repeat (5) @(negedge clk);
        {pulseThree, pulseTwo, pulseOne} = 3'h0;
        repeat (6) @(negedge clk);
    endtask
    // Third cycle length: pulse two, then pulse three
    task automatic cyc(input int n);
        if (n == 3) begin
            pulse(2);
        end
        pulse(n);
    endtask
endmodule // hsdp_host

// ### hsdp_checker_assertions.sv
`timescale 1ns/100ps
module hsdp_checker (
    input wire logic        clk, rst_n, pulseOne, pulseTwo, pulseThree, holdingLoadEnable,
    input wire logic        shiftSelectLow, shiftSelectHigh, multiplyActive, combinedArithShift,
    input wire logic [15:0] holdingWord, shiftingWord
);
    logic [6:0]  ha, hs;
    logic [15:0] ph, pw;
    wire logic [1:0] sel = {shiftSelectHigh, shiftSelectLow};
    wire logic fa = |(ha[6:1] & ~ha[5:0]);
    wire logic fs = |(hs[6:1] & ~hs[5:0]);
    always_ff @(posedge clk) begin
        ha <= {ha[5:0], pulseOne | pulseThree};
        hs <= {hs[5:0], pulseOne | pulseTwo};
        ph <= holdingWord;
        pw <= shiftingWord;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rst; disable iff (1'b0) !rst_n |=> holdingWord == 16'h0000 && shiftingWord == 16'h0000; endproperty
    a_rst: assert property (p_rst) else $error("no clear");
    property p_ha; $changed(holdingWord) |-> fa; endproperty
    a_ha: assert property (p_ha) else $error("hold moved");
    property p_sh; $changed(shiftingWord) |-> fs; endproperty
    a_sh: assert property (p_sh) else $error("shift moved");
    property p_en; (!holdingLoadEnable)[*8] |=> $stable(holdingWord); endproperty
    a_en: assert property (p_en) else $error("load off");
    property p_nop; (sel == 2'h0)[*8] |=> $stable(shiftingWord); endproperty
    a_nop: assert property (p_nop) else $error("nop");
    property p_ld; (sel == 2'h3)[*8] ##0 $changed(shiftingWord) |-> shiftingWord == ph; endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_rt; (sel == 2'h1 && !multiplyActive)[*8] ##0 $changed(shiftingWord) |-> shiftingWord == {ph[0], pw[15:1]}; endproperty
    a_rt: assert property (p_rt) else $error("right");
    property p_lf; (sel == 2'h2 && combinedArithShift)[*8] ##0 $changed(shiftingWord) |-> shiftingWord == {pw[14:0], 1'b0}; endproperty
    a_lf: assert property (p_lf) else $error("left");
    c_ld: cover property (sel == 2'h3 ##1 $changed(shiftingWord));
    c_rt: cover property (sel == 2'h1 ##1 $changed(shiftingWord));
    c_ha: cover property ($changed(holdingWord));
endmodule // hsdp_checker
bind hsdp_datapath hsdp_checker i_hsdp_checker (.*);

// ### tb_hsdp_datapath.sv
`timescale 1ns/100ps
module tb_hsdp_datapath;
    logic clk = 1'b0, rst_n = 1'b0, holdingLoadEnable = 1'b0, shiftSelectLow = 1'b0, shiftSelectHigh = 1'b0;
    logic multiplyActive = 1'b0, divideActive = 1'b0, combinedArithShift = 1'b0;
    logic quotientBit = 1'b0, arithUnitLsb = 1'b0, floatHighMsb = 1'b0;
    logic [2:0]  generalPurposeCode = 3'h0;
    logic [15:0] hostDataSelect = 16'h0000, expH, expS, expSi;
    logic [47:0] q[$];
    wire logic pulseOne, pulseTwo, pulseThree;
    wire logic [15:0] holdingWord, shiftingWord, shiftingWordInt;
    int n_errors = 0, samples_checked = 0, seed = 11300, p;
    event done;
    always #10 clk = ~clk;
    hsdp_host i_hsdp_host (.*);
    hsdp_datapath i_hsdp_datapath (.*);
    // Integer-only build: float link strapped off
    hsdp_datapath #(
        .FLOAT_PRESENT (1'b0)
    ) i_hsdp_datapath_int (
        .clk                (clk),
        .rst_n              (rst_n),
        .pulseOne           (pulseOne),
        .pulseTwo           (pulseTwo),
        .pulseThree         (pulseThree),
        .hostDataSelect     (hostDataSelect),
        .holdingLoadEnable  (holdingLoadEnable),
        .shiftSelectLow     (shiftSelectLow),
        .shiftSelectHigh    (shiftSelectHigh),
        .generalPurposeCode (generalPurposeCode),
        .multiplyActive     (multiplyActive),
        .divideActive       (divideActive),
        .combinedArithShift (combinedArithShift),
        .quotientBit        (quotientBit),
        .arithUnitLsb       (arithUnitLsb),
        .floatHighMsb       (floatHighMsb),
        .holdingWord        (),
        .shiftingWord       (shiftingWordInt)
    );
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED words expected %h seen %h", exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always begin
        @(done);
        check({holdingWord, shiftingWord, shiftingWordInt}, q.pop_front());
    end
    task automatic reset_dut;
        @(negedge clk) rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        {expH, expS, expSi} = 48'h0;
        q.push_back(48'h0);
        -> done;
    endtask
    function automatic logic [15:0] next_shift(input logic [15:0] s, input logic [15:0] h, input logic f);
        case ({shiftSelectHigh, shiftSelectLow})
            2'h1: return {multiplyActive ? arithUnitLsb : h[0], s[15:1]};
            2'h2: return {s[14:0], f};
            2'h3: return h;
            default: return s;
        endcase
    endfunction
    task automatic step;
        logic [15:0] nH;
        logic        fill;
        logic        fillInt;
        @(negedge clk);
        {hostDataSelect, holdingLoadEnable, shiftSelectHigh, shiftSelectLow, generalPurposeCode} = 22'($random(seed));
        {multiplyActive, divideActive, combinedArithShift, quotientBit, arithUnitLsb, floatHighMsb} = 6'($random(seed));
        p = 1 + $unsigned($random(seed)) % 3;
        i_hsdp_host.cyc(p);
        nH = (holdingLoadEnable && p != 2) ? hostDataSelect : expH;
        fill = combinedArithShift ? 1'b0 : generalPurposeCode == 3'h5 ? floatHighMsb : divideActive & quotientBit;
        fillInt = combinedArithShift ? 1'b0 : divideActive & quotientBit;
        // Each cycle length has one shift pulse, on the same edge as any load or ahead of it
        expS = next_shift(expS, expH, fill);
        expSi = next_shift(expSi, expH, fillInt);
        expH = nH;
        q.push_back({expH, expS, expSi});
        -> done;
    endtask
    initial begin
        for (int k = 0; k < 2; k++) begin
            reset_dut();
            repeat (40) step();
            $display("phase %0d done", k);
        end
        @(negedge clk);
        stop_test();
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end
endmodule // tb_hsdp_datapath
